// [hdl/tmr_core.sv]
// Three cascadable 16-bit auto-reloading timers with AXI4-Lite registers
//
// Chosen here: the address map and register access over AXI4-Lite.
`include "tmr_defines.svh"

// Functional notes
// - Each timer is a 16-bit counter reloading automatically on wrap.
// - Count moving from all ones to all zeros is overflow.
// - Count moving from all zeros to all ones is underflow.
// - Timer 2 cascades from timer 1, timer 3 from timer 2; timer 1 none.
// - One clock enable per tick rate; any one selectable as tick.
// - Watchdog reset returns all timers and control state to defaults.
// - Control reset bit resets that one timer.
// - Overflow or underflow raises that timer's interrupt request.
// - Three interrupt requests drive three bits of one source group.
// - No interrupt while the timer enable bit is clear.
// - Power-down bit drops the timer clock request.
// - In sleep the tick is gated and the interrupt forced inactive.
// - Leaving sleep, an enabled timer restarts from its preload value.
// - Timer stops at the next selected tick after sleep request asserts.
// - Request stays 1 until idle, up to one tick, then 0.
// - With power-down and sleep both clear, request held at 1.
// - Underflow reloads from reload register if select set or a reload write is pending, else all ones.
// - Reload write copies to counter when stopped, else at next underflow.
module tmr_core (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic                      clk_en,
  input  wire logic                      watchdog_reset_n,
  input  wire logic [`TMR_NUM_DIV-1:0]   divided_clock_enables,
  input  wire logic                      sleep_request,
  output logic [`TMR_NUM_TIMERS-1:0]     timer_irq,
  output logic [`TMR_NUM_TIMERS-1:0]     timer_clock_request,
  output logic [`TMR_NUM_TIMERS-1:0]     timer_overflow,
  input  wire logic [7:0]                s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [7:0]                s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready
);
  localparam int NT = `TMR_NUM_TIMERS;
  localparam int CW = `TMR_CNT_W;

  // ************************************************************
  // Address decode
  // ************************************************************
  function automatic logic [2:0] dec_idx(input logic [7:0] a);
    dec_idx = {1'b0, a[5:4]};
    if (a[7:6] != 2'b00 || a[5:4] == 2'b11 || a[1:0] != 2'b00 || a[3:2] == 2'b11) begin
      dec_idx = 3'h7;
    end
  endfunction

  logic                rst_all;
  logic [7:0]          aw_ff;
  logic [31:0]         w_ff;
  logic [3:0]          ws_ff;
  logic                aw_ok_ff;
  logic                w_ok_ff;
  logic                bvalid_ff;
  logic [1:0]          bresp_ff;
  logic                rvalid_ff;
  logic [1:0]          rresp_ff;
  logic [31:0]         rdata_ff;
  logic                wr_go;
  logic [2:0]          wr_t;
  logic                sleep_m_ff;
  logic                sleep_ff;

  assign rst_all = !aresetn || !watchdog_reset_n;
  assign wr_go   = aw_ok_ff && w_ok_ff && !bvalid_ff;
  assign wr_t    = dec_idx(aw_ff);

  // ************************************************************
  // AXI4-Lite slave
  // ************************************************************
  assign s_axi_awready = !aw_ok_ff && !bvalid_ff;
  assign s_axi_wready  = !w_ok_ff && !bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = rdata_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_ff  <= 1'b0;
      w_ok_ff   <= 1'b0;
      aw_ff     <= 8'h00;
      w_ff      <= 32'h0000_0000;
      ws_ff     <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= `TMR_RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok_ff <= 1'b1;
        aw_ff    <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok_ff <= 1'b1;
        w_ff    <= s_axi_wdata;
        ws_ff   <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_ok_ff  <= 1'b0;
        w_ok_ff   <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff  <= (wr_t == 3'h7) ? `TMR_RESP_SLVERR : `TMR_RESP_OKAY;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Sleep request synchroniser
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sleep_m_ff <= 1'b0;
      sleep_ff   <= 1'b0;
    end else if (clk_en) begin
      sleep_m_ff <= sleep_request;
      sleep_ff   <= sleep_m_ff;
    end
  end

  // ************************************************************
  // Timer instances
  // ************************************************************
  tmr_pkg::tmr_ctrl_t ctrl_ff   [NT];
  logic [CW-1:0]      reload_ff [NT];
  logic [CW-1:0]      cnt_ff    [NT];
  logic [NT-1:0]      wrap_ff;
  logic [NT-1:0]      casc_in;
  logic [NT-1:0]      casc_q_ff;
  tmr_pkg::tmr_pstate_t pst_ff  [NT];

  assign casc_in = {wrap_ff[NT-2:0], 1'b0};
  assign timer_overflow = wrap_ff;

  genvar g;
  generate
    for (g = 0; g < NT; g++) begin : g_tmr
      logic        sel_w;
      logic        wsel_c;
      logic        wsel_r;
      logic        tick;
      logic        run;
      logic        rl_pend_ff;
      logic        at_max;
      logic        at_min;
      logic        soft_rst;
      logic [7:0]  wb0;

      assign sel_w    = wr_go && (wr_t == 3'(g));
      assign wsel_c   = sel_w && (aw_ff[3:0] == `TMR_OFS_CTRL) && ws_ff[0];
      assign wsel_r   = sel_w && (aw_ff[3:0] == `TMR_OFS_RELOAD);
      assign wb0      = w_ff[7:0];
      assign soft_rst = clk_en && wsel_c && wb0[`TMR_CTRL_RESET];
      assign run      = ctrl_ff[g].enable && !ctrl_ff[g].pd && pst_ff[g] != tmr_pkg::TMR_SLEEPING;
      assign at_max   = cnt_ff[g] == `TMR_ALL_ONES;
      assign at_min   = cnt_ff[g] == `TMR_ALL_ZERO;
      // Event mode counts cascade edges, timer mode the selected rate
      assign tick     = run && (ctrl_ff[g].event_mode ? (casc_in[g] && !casc_q_ff[g])
                                                      : divided_clock_enables[ctrl_ff[g].clksel]);

      // ************************************************************
      // Control and reload registers
      // ************************************************************
      always_ff @(posedge aclk) begin
        if (rst_all || soft_rst) begin
          ctrl_ff[g] <= tmr_pkg::tmr_ctrl_t'(0);
        end else if (clk_en && wsel_c) begin
          ctrl_ff[g].enable     <= wb0[`TMR_CTRL_ENABLE];
          ctrl_ff[g].pd         <= wb0[`TMR_CTRL_PD];
          ctrl_ff[g].reload_on_wrap_select      <= wb0[`TMR_CTRL_RELOAD_ON_WRAP_SELECT];
          ctrl_ff[g].updn       <= wb0[`TMR_CTRL_UPDN];
          ctrl_ff[g].event_mode <= wb0[`TMR_CTRL_EVENT];
          ctrl_ff[g].clksel     <= ws_ff[1] ? w_ff[`TMR_CTRL_CLKSEL_LO +: 3] : ctrl_ff[g].clksel;
        end
      end

      always_ff @(posedge aclk) begin
        if (rst_all || soft_rst) begin
          reload_ff[g] <= `TMR_RELOAD_RST;
        end else if (clk_en && wsel_r) begin
          reload_ff[g] <= w_ff[CW-1:0];
        end
      end

      // ************************************************************
      // Counter with wrap detection and reload
      // ************************************************************
      always_ff @(posedge aclk) begin
        if (rst_all || soft_rst) begin
          cnt_ff[g]     <= `TMR_RELOAD_RST;
          wrap_ff[g]    <= 1'b0;
          rl_pend_ff    <= 1'b0;
          casc_q_ff[g]  <= 1'b0;
        end else if (clk_en) begin
          wrap_ff[g]   <= 1'b0;
          casc_q_ff[g] <= casc_in[g];
          if (wsel_r && !run) begin
            cnt_ff[g]  <= w_ff[CW-1:0];
          end else if (pst_ff[g] == tmr_pkg::TMR_SLEEPING) begin
            cnt_ff[g]  <= reload_ff[g];
          end else if (tick) begin
            if (ctrl_ff[g].event_mode && ctrl_ff[g].updn) begin
              cnt_ff[g] <= at_max ? (ctrl_ff[g].reload_on_wrap_select ? reload_ff[g] : `TMR_ALL_ZERO)
                                  : cnt_ff[g] + 16'h0001;
              wrap_ff[g] <= at_max;
            end else begin
              cnt_ff[g] <= at_min ? ((ctrl_ff[g].reload_on_wrap_select || rl_pend_ff) ? reload_ff[g] : `TMR_ALL_ONES)
                                  : cnt_ff[g] - 16'h0001;
              wrap_ff[g] <= at_min;
            end
          end
          if (wsel_r && run) begin
            rl_pend_ff <= 1'b1;
          end else if (tick && at_min) begin
            rl_pend_ff <= 1'b0;
          end
        end
      end

      // ************************************************************
      // Low power handshake
      // ************************************************************
      always_ff @(posedge aclk) begin
        if (rst_all || soft_rst) begin
          pst_ff[g] <= tmr_pkg::TMR_NORMAL;
        end else if (clk_en) begin
          unique case (pst_ff[g])
            tmr_pkg::TMR_NORMAL: begin
              if (ctrl_ff[g].pd || sleep_ff) begin
                pst_ff[g] <= tmr_pkg::TMR_PREPARING;
              end
            end
            tmr_pkg::TMR_PREPARING: begin
              if (!ctrl_ff[g].pd && !sleep_ff) begin
                pst_ff[g] <= tmr_pkg::TMR_NORMAL;
              end else if (divided_clock_enables[ctrl_ff[g].clksel] || !ctrl_ff[g].enable) begin
                pst_ff[g] <= tmr_pkg::TMR_SLEEPING;
              end
            end
            tmr_pkg::TMR_SLEEPING: begin
              if (!ctrl_ff[g].pd && !sleep_ff) begin
                pst_ff[g] <= tmr_pkg::TMR_NORMAL;
              end
            end
            default: begin
              pst_ff[g] <= tmr_pkg::TMR_NORMAL;
            end
          endcase
        end
      end

      assign timer_clock_request[g] = pst_ff[g] != tmr_pkg::TMR_SLEEPING;
      // One-cycle pulse, gated by enable and sleep
      assign timer_irq[g] = wrap_ff[g] && ctrl_ff[g].enable && pst_ff[g] != tmr_pkg::TMR_SLEEPING;
    end
  endgenerate

  // ************************************************************
  // Read path
  // ************************************************************
  logic [2:0] rd_t;
  assign rd_t = dec_idx(s_axi_araddr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rresp_ff  <= `TMR_RESP_OKAY;
      rdata_ff  <= 32'h0000_0000;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_ff <= 1'b1;
        rresp_ff  <= (rd_t == 3'h7) ? `TMR_RESP_SLVERR : `TMR_RESP_OKAY;
        rdata_ff  <= 32'h0000_0000;
        if (rd_t != 3'h7) begin
          unique case (s_axi_araddr[3:2])
            2'b00:   rdata_ff <= {21'h0, ctrl_ff[rd_t[1:0]].clksel, 2'b00, ctrl_ff[rd_t[1:0]].event_mode,
                                  ctrl_ff[rd_t[1:0]].updn, ctrl_ff[rd_t[1:0]].reload_on_wrap_select,
                                  ctrl_ff[rd_t[1:0]].pd, 1'b0, ctrl_ff[rd_t[1:0]].enable};
            2'b01:   rdata_ff <= {16'h0000, reload_ff[rd_t[1:0]]};
            default: rdata_ff <= {16'h0000, cnt_ff[rd_t[1:0]]};
          endcase
        end
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end
endmodule

// [hdl/tmr_defines.svh]
// Register offsets, field positions and reset values of the timer block
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH
`define TMR_NUM_TIMERS     3
`define TMR_CNT_W          16
`define TMR_NUM_DIV        8
`define TMR_REG_STRIDE     8'h10
`define TMR_OFS_CTRL       4'h0
`define TMR_OFS_RELOAD     4'h4
`define TMR_OFS_COUNT      4'h8
`define TMR_CTRL_ENABLE    0
`define TMR_CTRL_RESET     1
`define TMR_CTRL_PD        2
`define TMR_CTRL_RELOAD_ON_WRAP_SELECT     3
`define TMR_CTRL_UPDN      4
`define TMR_CTRL_EVENT     5
`define TMR_CTRL_CLKSEL_LO 8
`define TMR_CTRL_MASK      32'h0000_073D
`define TMR_CTRL_RESET_VAL 32'h0000_0000
`define TMR_RELOAD_RST     16'hFFFF
`define TMR_ALL_ONES       16'hFFFF
`define TMR_ALL_ZERO       16'h0000
`define TMR_RESP_OKAY      2'b00
`define TMR_RESP_SLVERR    2'b10
`endif

// [hdl/tmr_pkg.sv]
// Types shared by the timer block
package tmr_pkg;
  typedef struct packed {
    logic       updn;
    logic       event_mode;
    logic       reload_on_wrap_select;
    logic       pd;
    logic       enable;
    logic [2:0] clksel;
  } tmr_ctrl_t;

  typedef enum logic [1:0] {
    TMR_NORMAL,
    TMR_PREPARING,
    TMR_SLEEPING
  } tmr_pstate_t;
endpackage

// [verification/tmr_clkgen.sv]
// Divided clock enable source
module tmr_clkgen (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       fast,
  output logic     [7:0] divided_clock_enables
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Divider
  // ****
  logic [6:0] cnt_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) cnt_ff <= 7'h0;
    else cnt_ff <= cnt_ff + 7'h1;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) divided_clock_enables[i] = fast || ((cnt_ff & 7'((1 << i) - 1)) == 7'h0);
  end
endmodule

// [verification/tmr_core_asserts.sv]
// Checker on the timer block ports
module tmr_core_asserts (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       clk_en,
  input wire logic       watchdog_reset_n,
  input wire logic [7:0] divided_clock_enables,
  input wire logic       sleep_request,
  input wire logic [2:0] timer_irq,
  input wire logic [2:0] timer_clock_request,
  input wire logic [2:0] timer_overflow,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Properties
  // ****
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  irq_single_a: assert property (clk_en && $past(clk_en) |-> (timer_irq & $past(timer_irq)) == 3'b000)
    else $error("irq pulse longer than one cycle");
  irq_wrap_a: assert property ((timer_irq & ~timer_overflow) == 3'b000)
    else $error("irq without wrap");
  wdog_quiet_a: assert property (!watchdog_reset_n |=> (timer_irq == 3'b000) [*2])
    else $error("irq after watchdog reset");
  sleep_quiet_a: assert property ((timer_irq & ~timer_clock_request) == 3'b000)
    else $error("irq while sleeping");
  sleep_stop_a: assert property ((clk_en && sleep_request && divided_clock_enables == 8'hFF) [*6]
    |-> timer_clock_request == 3'b000) else $error("clock request held too long");
  wake_a: assert property ((clk_en && watchdog_reset_n && !sleep_request) [*5] ##1 !watchdog_reset_n
    |=> ##1 timer_clock_request == 3'b111) else $error("clock request not restored");
  rd_answer_a: assert property (clk_en && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  wr_answer_a: assert property (clk_en && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  busy_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
endmodule

// [verification/tmr_core_tb.sv]
// Self-checking bench for the three-timer block
`include "tmr_defines.svh"
module tmr_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Signals
  // ****
  logic        aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1, watchdog_reset_n = 1'b1, sleep_request = 1'b0;
  logic        fast = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  divided_clock_enables, s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp, bq[$];
  logic [2:0]  timer_irq, timer_clock_request, timer_overflow, seen = 3'h0;
  logic [33:0] rq[$];
  logic [15:0] v;
  int          fail_count = 0, n_compared = 0;
  always #5 aclk = ~aclk;
  tmr_clkgen u_tmr_clkgen (.aclk, .aresetn, .fast, .divided_clock_enables);
  tmr_core u_tmr_core (.aclk, .aresetn, .clk_en, .watchdog_reset_n, .divided_clock_enables, .sleep_request,
    .timer_irq, .timer_clock_request, .timer_overflow, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // ****
  // Tasks
  // ****
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic await(input int k, input int i, input logic lv, input int lim = 4000);
    int   n;
    logic s;
    for (n = 0; n < lim; n++) begin
      @(negedge aclk);
      case (k)
        0: s = seen[i];
        1: s = timer_clock_request[i];
        2: s = s_axi_arready;
        3: s = s_axi_rvalid;
        4: s = s_axi_bvalid;
        default: s = s_axi_awready && s_axi_wready;
      endcase
      if (s === lv) break;
    end
    @(posedge aclk);
    if (k == 0) seen[i] = 1'b0;
    if (k < 2) n_compared++;
    if (n == lim) begin
      fail_count++;
      $display("unexpected at %0t: wait ran out", $time);
      conclude();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = `TMR_RESP_OKAY);
    @(posedge aclk);
    rq.push_back({d, r});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    await(2, 0, 1'b1);
    s_axi_arvalid <= 1'b0;
    await(3, 0, 1'b1);
    s_axi_rready <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = `TMR_RESP_OKAY);
    int   n;
    logic aw_hs;
    logic w_hs;
    logic aw_now;
    logic w_now;
    @(posedge aclk);
    bq.push_back(r);
    aw_hs = 1'b0;
    w_hs = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // Each channel is released at the edge that takes it
    for (n = 0; n < 4000 && !(aw_hs && w_hs); n++) begin
      @(negedge aclk);
      aw_now = !aw_hs && s_axi_awready;
      w_now = !w_hs && s_axi_wready;
      @(posedge aclk);
      if (aw_now) s_axi_awvalid <= 1'b0;
      if (w_now) s_axi_wvalid <= 1'b0;
      aw_hs = aw_hs || aw_now;
      w_hs = w_hs || w_now;
    end
    if (!(aw_hs && w_hs)) begin
      fail_count++;
      $display("unexpected at %0t: write address or data not taken", $time);
      conclude();
    end
    await(4, 0, 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  // ****
  // Result watcher
  // ****
  always @(negedge aclk) begin
    seen <= seen | timer_irq;
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rdata, s_axi_rresp}, rq.pop_front());
    if (s_axi_bvalid && s_axi_bready) chk({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
  end
  // ****
  // Main sequence
  // ****
  initial begin
    void'($urandom(32'h9355_db8f));
    v = 16'($urandom_range(15, 1));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00, 32'h0000_0000);
    rd(8'h14, 32'h0000_FFFF);
    rd(8'h28, 32'h0000_FFFF);
    rd(8'h0C, 32'h0000_0000, `TMR_RESP_SLVERR);
    wr(8'h3C, 32'h0000_0001, `TMR_RESP_SLVERR);
    $display("test reset values done");
    wr(8'h24, 32'h0000_0000);
    rd(8'h28, 32'h0000_0000);
    wr(8'h10, 32'h0000_0731);
    wr(8'h20, 32'h0000_0721);
    wr(8'h04, 32'h0000_0003);
    rd(8'h08, 32'h0000_0003);
    wr(8'h00, 32'h0000_0709);
    await(0, 1, 1'b1);
    rd(8'h18, 32'h0000_0000);
    await(0, 2, 1'b1);
    rd(8'h28, 32'h0000_FFFF);
    seen[0] = 1'b0;
    await(0, 0, 1'b1);
    rd(8'h08, 32'h0000_0003);
    wr(8'h04, {16'h0, v});
    await(0, 0, 1'b1);
    rd(8'h08, {16'h0, v});
    wr(8'h00, 32'h0000_0701);
    await(0, 0, 1'b1);
    rd(8'h08, 32'h0000_FFFF);
    $display("test wrap and cascade done");
    for (int k = 0; k < 8; k++) begin
      wr(8'h00, 32'h0000_0002);
      wr(8'h04, 32'h0000_0001);
      seen[0] = 1'b0;
      wr(8'h00, {21'h0, k[2:0], 8'h09});
      repeat (1 << k) @(posedge aclk);
      chk({33'h0, seen[0]}, 34'h0);
      await(0, 0, 1'b1, (1 << k) + 4);
    end
    wr(8'h00, 32'h0000_0002);
    rd(8'h00, 32'h0000_0000);
    rd(8'h04, 32'h0000_FFFF);
    rd(8'h08, 32'h0000_FFFF);
    $display("test tick select and reset bit done");
    wr(8'h20, 32'h0000_0004);
    await(1, 2, 1'b0);
    wr(8'h20, 32'h0000_0000);
    await(1, 2, 1'b1);
    wr(8'h04, 32'h0000_0040);
    wr(8'h00, 32'h0000_0701);
    sleep_request <= 1'b1;
    fast <= 1'b1;
    await(1, 0, 1'b0);
    rd(8'h08, 32'h0000_0040);
    sleep_request <= 1'b0;
    fast <= 1'b0;
    await(1, 0, 1'b1);
    $display("test power down and sleep done");
    @(posedge aclk);
    watchdog_reset_n <= 1'b0;
    @(posedge aclk);
    watchdog_reset_n <= 1'b1;
    rd(8'h10, 32'h0000_0000);
    rd(8'h24, 32'h0000_FFFF);
    rd(8'h08, 32'h0000_FFFF);
    $display("test watchdog reset done");
    conclude();
  end
endmodule
bind tmr_core tmr_core_asserts u_tmr_core_asserts (.aclk, .aresetn, .clk_en, .watchdog_reset_n,
  .divided_clock_enables, .sleep_request, .timer_irq, .timer_clock_request, .timer_overflow, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);
